// ==== design/phy_power_mode_control.v ====
// Power mode control of the transceiver with an Avalon-MM register port.
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "phy_power_mode_regs.vh"
module phy_power_mode_control (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire [4:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] i_writedata,
  input wire [3:0] i_byteenable,
  output reg [31:0] o_readdata,
  output wire o_waitrequest,
  input wire i_link_up,
  input wire i_energy_detect,
  output reg o_rx_blocks_en,
  output reg o_tx_en,
  output reg o_energy_det_en,
  output reg o_pll_en,
  output reg o_digital_en,
  output reg o_slow_osc_sel,
  output reg o_crystal_clock_input_en,
  output reg o_link_pulse,
  output reg o_soft_reset
);
  localparam [4:0] ST_NORMAL = 5'h01;
  localparam [4:0] ST_PWR_SAVE = 5'h02;
  localparam [4:0] ST_ENERGY_DETECT_POWERDOWN = 5'h04;
  localparam [4:0] ST_POWER_DOWN = 5'h08;
  localparam [4:0] ST_RESET = 5'h10;
  localparam integer TICK_CYC_I = `PULSE_TICK_CYC;
  localparam integer PULSE_W_I = `PULSE_WIDTH_CYC;
  localparam integer SRST_W_I = `SRST_HOLD_CYC;
  localparam [15:0] TICK_CYC = TICK_CYC_I[15:0];
  localparam [3:0] PULSE_W = PULSE_W_I[3:0];
  localparam [3:0] SRST_W = SRST_W_I[3:0];

  reg [15:0] basic_ctrl_q;
  reg [15:0] pll_ctrl_q;
  reg [15:0] osc_ctrl_q;
  reg [15:0] energy_detect_powerdown_ctrl_q;
  reg [15:0] phy_ctrl2_q;
  reg [15:0] pulse_gap_q;
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg wait_q;
  reg [15:0] tick_cnt_q;
  reg [3:0] pulse_cnt_q;
  reg [3:0] srst_cnt_q;
  reg [15:0] wmask;
  reg [15:0] rd_mux;
  reg rx_en_d;
  reg tx_en_d;
  reg ed_en_d;
  reg pll_en_d;
  reg dig_en_d;
  wire access;
  wire wr_go;
  wire rd_go;
  wire autoneg_on;
  wire no_link;
  wire wake;
  wire save_req;
  wire energy_detect_powerdown_req;
  wire tick_1us;
  wire in_energy_detect_powerdown;

  // One wait cycle per access keeps the answer registered and predictable.
  assign access = i_read | i_write;
  assign o_waitrequest = access & ~wait_q;
  assign wr_go = i_write & wait_q;
  // Read data are captured in the waiting cycle so that they stand at the completing edge.
  assign rd_go = i_read & ~wait_q;

  always @* begin
    wmask = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  end

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= access & ~wait_q;
    end
  end

  function [15:0] merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [15:0] m;
    begin
      merge = (old_v & ~m) | (new_v & m);
    end
  endfunction

  // Software reset restores every mode bit; the reset bit itself self-clears.
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      basic_ctrl_q <= `RST_BASIC_CTRL;
      pll_ctrl_q <= `RST_PLL_CTRL;
      osc_ctrl_q <= `RST_OSC_CTRL;
      energy_detect_powerdown_ctrl_q <= `RST_ENERGY_DETECT_POWERDOWN_CTRL;
      phy_ctrl2_q <= `RST_PHY_CTRL2;
      pulse_gap_q <= `RST_PULSE_GAP;
    end else if (state_q == ST_RESET && srst_cnt_q == SRST_W) begin
      basic_ctrl_q <= `RST_BASIC_CTRL;
      pll_ctrl_q <= `RST_PLL_CTRL;
      osc_ctrl_q <= `RST_OSC_CTRL;
      energy_detect_powerdown_ctrl_q <= `RST_ENERGY_DETECT_POWERDOWN_CTRL;
      phy_ctrl2_q <= `RST_PHY_CTRL2;
      pulse_gap_q <= `RST_PULSE_GAP;
    end else if (wr_go) begin
      case (i_address)
        `REG_BASIC_CTRL: basic_ctrl_q <= merge(basic_ctrl_q, i_writedata[15:0], wmask);
        `REG_PLL_CTRL: pll_ctrl_q <= merge(pll_ctrl_q, i_writedata[15:0], wmask);
        `REG_OSC_CTRL: osc_ctrl_q <= merge(osc_ctrl_q, i_writedata[15:0], wmask);
        `REG_ENERGY_DETECT_POWERDOWN_CTRL: energy_detect_powerdown_ctrl_q <= merge(energy_detect_powerdown_ctrl_q, i_writedata[15:0], wmask);
        `REG_PHY_CTRL2: phy_ctrl2_q <= merge(phy_ctrl2_q, i_writedata[15:0], wmask);
        `REG_PULSE_GAP: pulse_gap_q <= merge(pulse_gap_q, i_writedata[15:0], wmask);
        default: pulse_gap_q <= pulse_gap_q;
      endcase
    end
  end

  always @* begin
    case (i_address)
      `REG_BASIC_CTRL: rd_mux = basic_ctrl_q;
      `REG_PLL_CTRL: rd_mux = pll_ctrl_q;
      `REG_OSC_CTRL: rd_mux = osc_ctrl_q;
      `REG_ENERGY_DETECT_POWERDOWN_CTRL: rd_mux = energy_detect_powerdown_ctrl_q;
      `REG_PHY_CTRL2: rd_mux = phy_ctrl2_q;
      `REG_PULSE_GAP: rd_mux = pulse_gap_q;
      `REG_PWR_STATUS: rd_mux = {9'h000, i_energy_detect, i_link_up, state_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_readdata <= 32'h00000000;
    end else if (rd_go) begin
      o_readdata <= {16'h0000, rd_mux};
    end
  end

  assign autoneg_on = basic_ctrl_q[`BIT_AUTONEG_EN];
  assign no_link = ~i_link_up;
  assign wake = i_energy_detect | i_link_up;
  assign save_req = phy_ctrl2_q[`BIT_PWR_SAVE] & autoneg_on & no_link;
  assign energy_detect_powerdown_req = ~energy_detect_powerdown_ctrl_q[`BIT_ENERGY_DETECT_POWERDOWN_DIS] & autoneg_on & no_link;

  // Power-down outranks both cable-driven modes; ENERGY_DETECT_POWERDOWN outranks power-saving.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL: begin
        if (basic_ctrl_q[`BIT_POWER_DOWN]) begin
          state_d = ST_POWER_DOWN;
        end else if (energy_detect_powerdown_req & ~wake) begin
          state_d = ST_ENERGY_DETECT_POWERDOWN;
        end else if (save_req & ~wake) begin
          state_d = ST_PWR_SAVE;
        end
      end
      ST_PWR_SAVE, ST_ENERGY_DETECT_POWERDOWN: begin
        if (basic_ctrl_q[`BIT_POWER_DOWN]) begin
          state_d = ST_POWER_DOWN;
        end else if (wake | ~(energy_detect_powerdown_req | save_req)) begin
          state_d = ST_NORMAL;
        end else if (energy_detect_powerdown_req) begin
          state_d = ST_ENERGY_DETECT_POWERDOWN;
        end else begin
          state_d = ST_PWR_SAVE;
        end
      end
      ST_POWER_DOWN: begin
        if (!basic_ctrl_q[`BIT_POWER_DOWN]) begin
          state_d = ST_NORMAL;
        end
      end
      ST_RESET: begin
        if (srst_cnt_q == SRST_W) begin
          state_d = ST_NORMAL;
        end
      end
      default: state_d = ST_NORMAL;
    endcase
    if (basic_ctrl_q[`BIT_SOFT_RESET] && state_q != ST_RESET) begin
      state_d = ST_RESET;
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_NORMAL;
      srst_cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_RESET) begin
        srst_cnt_q <= srst_cnt_q + 4'h1;
      end else begin
        srst_cnt_q <= 4'h0;
      end
    end
  end

  assign in_energy_detect_powerdown = (state_q == ST_ENERGY_DETECT_POWERDOWN);

  pulse_divider #(.WIDTH(16)) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_run(in_energy_detect_powerdown),
    .i_period(TICK_CYC - 16'h0001),
    .o_tick(tick_1us)
  );

  // Interval of pulse_gap_q + 1 microseconds; a longer gap saves more power.
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_q <= 16'h0000;
      pulse_cnt_q <= 4'h0;
      o_link_pulse <= 1'b0;
    end else if (!in_energy_detect_powerdown) begin
      tick_cnt_q <= 16'h0000;
      pulse_cnt_q <= 4'h0;
      o_link_pulse <= 1'b0;
    end else begin
      if (tick_1us) begin
        if (tick_cnt_q >= pulse_gap_q) begin
          tick_cnt_q <= 16'h0000;
          pulse_cnt_q <= PULSE_W;
        end else begin
          tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
      end else if (pulse_cnt_q != 4'h0) begin
        pulse_cnt_q <= pulse_cnt_q - 4'h1;
      end
      // A wake cuts a pulse short: nothing may go out once the receive side is back,
      // so the pulse follows the next state rather than the current one.
      o_link_pulse <= (pulse_cnt_q != 4'h0) && (state_d == ST_ENERGY_DETECT_POWERDOWN);
    end
  end

  // Enable pattern of each mode, taken from the next state so that the
  // enables switch at the same edge as the mode itself.
  always @* begin
    rx_en_d = 1'b1;
    tx_en_d = 1'b1;
    ed_en_d = 1'b1;
    pll_en_d = 1'b1;
    dig_en_d = 1'b1;
    case (state_d)
      ST_NORMAL: begin
        rx_en_d = 1'b1;
      end
      ST_RESET: begin
        // The receive side stays powered so that it restarts from a known state.
        rx_en_d = 1'b1;
      end
      ST_PWR_SAVE: begin
        rx_en_d = 1'b0;
      end
      ST_ENERGY_DETECT_POWERDOWN: begin
        rx_en_d = 1'b0;
        pll_en_d = ~pll_ctrl_q[`BIT_PLL_OFF];
      end
      ST_POWER_DOWN: begin
        // Only the register port stays alive, whichever clock is selected.
        rx_en_d = 1'b0;
        tx_en_d = 1'b0;
        ed_en_d = 1'b0;
        pll_en_d = 1'b0;
        dig_en_d = 1'b0;
      end
      default: begin
        rx_en_d = 1'b1;
      end
    endcase
  end

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_blocks_en <= 1'b1;
      o_tx_en <= 1'b1;
      o_energy_det_en <= 1'b1;
      o_pll_en <= 1'b1;
      o_digital_en <= 1'b1;
      o_slow_osc_sel <= 1'b0;
      o_crystal_clock_input_en <= 1'b1;
      o_soft_reset <= 1'b0;
    end else begin
      o_rx_blocks_en <= rx_en_d;
      o_tx_en <= tx_en_d;
      o_energy_det_en <= ed_en_d;
      o_pll_en <= pll_en_d;
      o_digital_en <= dig_en_d;
      o_slow_osc_sel <= osc_ctrl_q[`BIT_SLOW_OSC];
      o_crystal_clock_input_en <= ~osc_ctrl_q[`BIT_SLOW_OSC];
      o_soft_reset <= (state_d == ST_RESET);
    end
  end
endmodule

// ==== design/phy_power_mode_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the power mode block.
// What this block does
// - Power-saving runs when its enable bit is one, auto-negotiation is on and no link exists.
// - Power-saving turns off every transceiver part but the transmitter, energy detector, PLL and digital core.
// - The power-saving enable reads zero after reset until software writes it.
// - Energy-detect power-down is enabled by a zero in its bit and acts only with autoneg on and no link.
// - With the PLL-off bit set, energy-detect power-down also stops the PLL.
// - During energy-detect power-down link pulses keep going out at a programmable interval.
// - Energy-detect power-down is disabled after reset.
// - Writing one to the power-down bit disables everything but the management interface.
// - Writing the power-down bit back to zero leaves power-down.
// - Writing one to the slow-oscillator bit drops the clock input and selects the slow oscillator.
// - Slow oscillator plus power-down is the lowest state with only management alive.
`ifndef PHY_POWER_MODE_REGS_VH
`define PHY_POWER_MODE_REGS_VH
`define REG_BASIC_CTRL 5'h00
`define REG_PLL_CTRL 5'h10
`define REG_OSC_CTRL 5'h11
`define REG_ENERGY_DETECT_POWERDOWN_CTRL 5'h18
`define REG_PHY_CTRL2 5'h1F
`define REG_PULSE_GAP 5'h14
`define REG_PWR_STATUS 5'h15
`define BIT_SOFT_RESET 15
`define BIT_AUTONEG_EN 12
`define BIT_POWER_DOWN 11
`define BIT_PLL_OFF 4
`define BIT_SLOW_OSC 5
`define BIT_ENERGY_DETECT_POWERDOWN_DIS 11
`define BIT_PWR_SAVE 10
`define RST_BASIC_CTRL 16'h1000
`define RST_PLL_CTRL 16'h0000
`define RST_OSC_CTRL 16'h0000
`define RST_ENERGY_DETECT_POWERDOWN_CTRL 16'h0800
`define RST_PHY_CTRL2 16'h0000
`define RST_PULSE_GAP 16'h0028
`define PULSE_TICK_NS 1000
`define CLK_PERIOD_NS 25
`define PULSE_TICK_CYC (`PULSE_TICK_NS / `CLK_PERIOD_NS)
`define PULSE_WIDTH_CYC 4
`define SRST_HOLD_CYC 8
`endif

// ==== design/pulse_divider.v ====
// Programmable divider that emits a one-cycle enable every period.
`timescale 1ns/100ps
module pulse_divider #(
  parameter WIDTH = 16
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_run,
  input wire [WIDTH-1:0] i_period,
  output reg o_tick
);
  reg [WIDTH-1:0] count_q;

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_q <= {WIDTH{1'b0}};
      o_tick <= 1'b0;
    end else if (!i_run) begin
      count_q <= {WIDTH{1'b0}};
      o_tick <= 1'b0;
    end else if (count_q >= i_period) begin
      count_q <= {WIDTH{1'b0}};
      o_tick <= 1'b1;
    end else begin
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
      o_tick <= 1'b0;
    end
  end
endmodule

// ==== tb/mgmt_host.sv ====
// Management host model that issues Avalon-MM register accesses.
`timescale 1ns/100ps
module mgmt_host (
  input wire i_clk_sys,
  input wire i_waitrequest,
  input wire [31:0] i_readdata,
  output reg [4:0] o_address = 5'h00,
  output reg o_read = 1'h0,
  output reg o_write = 1'h0,
  output reg [31:0] o_writedata = 32'h00000000,
  output reg [3:0] o_byteenable = 4'h3
);
  // Each access begins one edge after the call, so no strobe is set twice in one step.
  task xfer(input rd, input [4:0] a, input [15:0] d, output [15:0] q);
    begin
      @(posedge i_clk_sys);
      o_address <= a;
      o_writedata <= {16'h0000, d};
      o_read <= rd;
      o_write <= !rd;
      @(posedge i_clk_sys);
      while (i_waitrequest) @(posedge i_clk_sys);
      // Waitrequest and read data are both taken as they stood at the completing edge.
      q = i_readdata[15:0];
      o_read <= 1'h0;
      o_write <= 1'h0;
    end
  endtask
endmodule

// ==== tb/phy_power_mode_control_assertions.sv ====
// Port-level checks of the power mode block.
`timescale 1ns/100ps
module phy_power_mode_control_assertions (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_read,
  input wire i_write,
  input wire o_waitrequest,
  input wire i_link_up,
  input wire i_energy_detect,
  input wire o_rx_blocks_en,
  input wire o_tx_en,
  input wire o_energy_det_en,
  input wire o_pll_en,
  input wire o_digital_en,
  input wire o_slow_osc_sel,
  input wire o_crystal_clock_input_en,
  input wire o_link_pulse,
  input wire o_soft_reset
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  // A wake may cut a pulse short, so a pulse ends early only when the receive side is back.
  sequence s_pulse4;
    (o_link_pulse || o_rx_blocks_en) [*4] ##1 !o_link_pulse;
  endsequence
  sequence s_srst9;
    o_soft_reset [*8] ##1 o_soft_reset ##1 !o_soft_reset;
  endsequence
  a_xtal_inverse: assert property (o_crystal_clock_input_en != o_slow_osc_sel)
    else $error("clock input enable does not oppose slow oscillator select");
  a_pd_all_off: assert property (!o_digital_en |->
    !o_tx_en && !o_pll_en && !o_rx_blocks_en && !o_energy_det_en)
    else $error("a block stays powered in power-down");
  a_save_keeps_tx: assert property (o_digital_en |-> o_tx_en && o_energy_det_en)
    else $error("transmitter or energy detector off outside power-down");
  a_pll_off_energy_detect_powerdown: assert property (o_digital_en && !o_pll_en |-> !o_rx_blocks_en)
    else $error("PLL off while receive blocks run");
  a_pulse_mode: assert property (o_link_pulse |-> o_digital_en && !o_rx_blocks_en)
    else $error("link pulse outside energy-detect power-down");
  a_pulse_width: assert property ($rose(o_link_pulse) |-> s_pulse4)
    else $error("link pulse width wrong");
  a_wake_link: assert property ((i_link_up || i_energy_detect) && o_digital_en
    |=> o_rx_blocks_en || !o_digital_en)
    else $error("no wake on link or energy");
  a_srst_len: assert property ($rose(o_soft_reset) |-> s_srst9)
    else $error("software reset length wrong");
  a_bus_wait: assert property ($rose(i_read || i_write) |-> o_waitrequest ##1 !o_waitrequest)
    else $error("waitrequest timing wrong");
endmodule
bind phy_power_mode_control phy_power_mode_control_assertions u_chk (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_read(i_read), .i_write(i_write),
  .o_waitrequest(o_waitrequest), .i_link_up(i_link_up), .i_energy_detect(i_energy_detect),
  .o_rx_blocks_en(o_rx_blocks_en), .o_tx_en(o_tx_en), .o_energy_det_en(o_energy_det_en),
  .o_pll_en(o_pll_en), .o_digital_en(o_digital_en), .o_slow_osc_sel(o_slow_osc_sel),
  .o_crystal_clock_input_en(o_crystal_clock_input_en), .o_link_pulse(o_link_pulse),
  .o_soft_reset(o_soft_reset));

// ==== tb/phy_power_mode_control_tb.sv ====
// Self-checking bench for the power mode block.
`timescale 1ns/100ps
`include "phy_power_mode_regs.vh"
module phy_power_mode_control_tb;
  reg clk = 1'h0;
  reg rst_b = 1'h0;
  reg link = 1'h0;
  reg energy = 1'h0;
  wire [4:0] addr;
  wire rd, wr, wreq, rx, tx, ed, pll, dig, slow, xtal, pulse, srst;
  wire [31:0] wdata, rdata;
  wire [3:0] be;
  reg [15:0] q;
  integer mismatches = 0;
  integer check_count = 0;
  integer n;
  initial forever #12.5 clk = ~clk;
  phy_power_mode_control dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_address(addr),
    .i_read(rd), .i_write(wr), .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata),
    .o_waitrequest(wreq), .i_link_up(link), .i_energy_detect(energy), .o_rx_blocks_en(rx),
    .o_tx_en(tx), .o_energy_det_en(ed), .o_pll_en(pll), .o_digital_en(dig),
    .o_slow_osc_sel(slow), .o_crystal_clock_input_en(xtal), .o_link_pulse(pulse),
    .o_soft_reset(srst));
  mgmt_host host (.i_clk_sys(clk), .i_waitrequest(wreq), .i_readdata(rdata), .o_address(addr),
    .o_read(rd), .o_write(wr), .o_writedata(wdata), .o_byteenable(be));
  task finish_test;
    begin
      if (mismatches == 0 && check_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rchk(input [4:0] a, input [15:0] exp);
    begin
      host.xfer(1'h1, a, 16'h0000, q);
      chk(q, exp);
    end
  endtask
  task wreg(input [4:0] a, input [15:0] d);
    host.xfer(1'h0, a, d, q);
  endtask
  // Enables in the order receive, transmit, energy detector, PLL, core.
  task pwr(input [4:0] exp);
    begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({11'h000, rx, tx, ed, pll, dig}, {11'h000, exp});
    end
  endtask
  task gap(output integer c);
    begin
      c = 0;
      while (pulse) @(negedge clk);
      while (!pulse && c < 2000) begin
        @(negedge clk);
        c = c + 1;
      end
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches = mismatches + 1;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    rchk(`REG_PHY_CTRL2, `RST_PHY_CTRL2);
    rchk(`REG_ENERGY_DETECT_POWERDOWN_CTRL, `RST_ENERGY_DETECT_POWERDOWN_CTRL);
    rchk(`REG_PWR_STATUS, 16'h0001);
    rchk(5'h05, 16'h0000);
    wreg(`REG_PWR_STATUS, 16'h00FF);
    rchk(`REG_PWR_STATUS, 16'h0001);
    wreg(`REG_PHY_CTRL2, 16'h0400);
    pwr(5'h0F);
    rchk(`REG_PWR_STATUS, 16'h0002);
    @(posedge clk);
    link <= 1'h1;
    pwr(5'h1F);
    @(posedge clk);
    link <= 1'h0;
    pwr(5'h0F);
    wreg(`REG_BASIC_CTRL, 16'h0000);
    pwr(5'h1F);
    wreg(`REG_BASIC_CTRL, 16'h1000);
    wreg(`REG_PULSE_GAP, 16'h0001);
    wreg(`REG_ENERGY_DETECT_POWERDOWN_CTRL, 16'h0000);
    rchk(`REG_PWR_STATUS, 16'h0004);
    gap(n);
    gap(n);
    chk(n[15:0], 2 * `PULSE_TICK_CYC - `PULSE_WIDTH_CYC);
    wreg(`REG_PLL_CTRL, 16'h0010);
    pwr(5'h0D);
    gap(n);
    repeat (6) @(posedge clk);
    energy <= 1'h1;
    pwr(5'h1F);
    wreg(`REG_BASIC_CTRL, 16'h1800);
    pwr(5'h00);
    wreg(`REG_OSC_CTRL, 16'h0020);
    pwr(5'h00);
    chk({14'h0000, slow, xtal}, 16'h0002);
    rchk(`REG_OSC_CTRL, 16'h0020);
    wreg(`REG_OSC_CTRL, 16'h0000);
    wreg(`REG_BASIC_CTRL, 16'h1000);
    pwr(5'h1F);
    wreg(`REG_BASIC_CTRL, 16'h9000);
    @(posedge clk);
    @(negedge clk);
    chk({15'h0000, srst}, 16'h0001);
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk({15'h0000, srst}, 16'h0000);
    rchk(`REG_ENERGY_DETECT_POWERDOWN_CTRL, `RST_ENERGY_DETECT_POWERDOWN_CTRL);
    rchk(`REG_PHY_CTRL2, `RST_PHY_CTRL2);
    finish_test;
  end
endmodule
